/* File: hdl/afe_pkg.sv */
// ****************************************************************************
// Shared constants and types of the front-end register bank
// ****************************************************************************
package afe_pkg;

   // Register addresses of the 4-bit map.
   localparam logic [3:0]  ADDR_CONTROL_STATUS    = 4'h0;
   localparam logic [3:0]  ADDR_CONVERSION_RESULT = 4'h1;
   localparam logic [3:0]  ADDR_EXCITATION_CONFIG = 4'h2;
   localparam logic [3:0]  ADDR_AMP_CONFIG        = 4'h3;
   localparam logic [3:0]  ADDR_CLOCK_CONFIG      = 4'h4;
   localparam logic [3:0]  ADDR_OPTION_CONFIG     = 4'h6;
   localparam logic [3:0]  ADDR_GAIN_COEFF_A      = 4'h8;
   localparam logic [3:0]  ADDR_GAIN_COEFF_B      = 4'h9;
   localparam logic [3:0]  ADDR_OFFSET_COEFF_A    = 4'hC;
   localparam logic [3:0]  ADDR_OFFSET_COEFF_B    = 4'hD;

   // Register lengths in bytes and the matching data masks.
   localparam logic [1:0]  LEN_NONE = 2'h0;
   localparam logic [1:0]  LEN_1    = 2'h1;
   localparam logic [1:0]  LEN_2    = 2'h2;
   localparam logic [1:0]  LEN_3    = 2'h3;
   localparam logic [23:0] MASK_1   = 24'h0000FF;
   localparam logic [23:0] MASK_2   = 24'h00FFFF;
   localparam logic [23:0] MASK_3   = 24'hFFFFFF;

   // Control/status field positions, widths and reset values.
   localparam int          NEG_SEL_LSB = 12;
   localparam int          POS_SEL_LSB = 8;
   localparam int          CNT_LSB     = 6;
   localparam int          PEND_BIT    = 5;
   localparam int          OVF_BIT     = 4;
   localparam int          MODE_LSB    = 0;
   localparam logic [2:0]  NEG_SEL_RST = 3'h4;
   localparam logic [2:0]  POS_SEL_RST = 3'h4;
   localparam logic [1:0]  CNT_RST     = 2'h0;
   localparam logic        PEND_RST    = 1'b1;
   localparam logic        OVF_RST     = 1'b0;
   localparam logic [15:0] RESULT_RST  = 16'h0000;

   // Operating mode codes.
   localparam logic [3:0]  MODE_IDLE   = 4'h0;
   localparam logic [3:0]  MODE_SINGLE = 4'h2;
   localparam logic [3:0]  MODE_CONT   = 4'h3;
   localparam logic [3:0]  MODE_BOOT   = 4'hF;

   // Reset values of the plain setup registers.
   localparam logic [23:0] EXC_RST  = 24'h000000;
   localparam logic [23:0] AMP_RST  = 24'h000000;
   localparam logic [23:0] CLK_RST  = 24'h000000;
   localparam logic [23:0] OPT_RST  = 24'h000000;
   localparam logic [23:0] GAIN_RST = 24'h000000;
   localparam logic [23:0] OFFS_RST = 24'h000000;

   // Serial command byte and frame bit counts.
   localparam logic [7:0]  CMD_RESET     = 8'hFF;
   localparam int          CMD_READ_BIT  = 7;
   localparam int          CMD_WRITE_BIT = 6;
   localparam logic [5:0]  CMD_LAST      = 6'h07;
   localparam logic [5:0]  TURN_LAST     = 6'h0F;
   localparam logic [5:0]  BITS_MAX      = 6'h3F;

   typedef enum logic [1:0] {ACC_RW = 2'h0, ACC_RO = 2'h1, ACC_WO = 2'h2, ACC_RC = 2'h3} afe_access_t;

   typedef struct packed {
      logic [15:0] excitation;
      logic [7:0]  amp;
      logic [7:0]  clock;
      logic [7:0]  option;
      logic [23:0] gain_a;
      logic [23:0] gain_b;
      logic [23:0] offset_a;
      logic [23:0] offset_b;
   } afe_cfg_t;

   typedef struct packed {
      logic        valid;
      logic        overflow;
      logic [15:0] data;
   } afe_conv_t;

   // Byte length of the register at an address, none for unused addresses.
   function automatic logic [1:0] afe_reg_len(input logic [3:0] addr);
      case (addr)
         ADDR_CONTROL_STATUS, ADDR_CONVERSION_RESULT, ADDR_EXCITATION_CONFIG: afe_reg_len = LEN_2;
         ADDR_AMP_CONFIG, ADDR_CLOCK_CONFIG, ADDR_OPTION_CONFIG:             afe_reg_len = LEN_1;
         ADDR_GAIN_COEFF_A, ADDR_GAIN_COEFF_B,
         ADDR_OFFSET_COEFF_A, ADDR_OFFSET_COEFF_B:                            afe_reg_len = LEN_3;
         default:                                                             afe_reg_len = LEN_NONE;
      endcase
   endfunction : afe_reg_len

   // Data mask for a byte length.
   function automatic logic [23:0] afe_len_mask(input logic [1:0] len);
      case (len)
         LEN_1:   afe_len_mask = MASK_1;
         LEN_2:   afe_len_mask = MASK_2;
         LEN_3:   afe_len_mask = MASK_3;
         default: afe_len_mask = 24'h000000;
      endcase
   endfunction : afe_len_mask

endpackage : afe_pkg

/* File: hdl/afe_spi_register_bank.sv */
// How it works
// - Four-bit address picks registers of one, two or three bytes each.
// - Reading a write-only field returns zero, not the stored value.
// - Read-clear bits read their value; writing one clears, writing zero keeps.
// - Power-on reset and serial reset command load every field's reset value.
// - Control bits 14 to 12 hold negative input select, reset value four.
// - Control bits 10 to 8 hold positive input select, reset four; 15, 11 unused.
// - Control bits 7 to 6 count result updates, wrapping modulo four.
// - Data pending flag at bit 5 drops to zero on each new result.
// - Reading the conversion result sets the data pending flag back to one.
// - Overflow flag at bit 4 goes to one when a result overflowed.
// - Reading the conversion result clears the overflow flag.
// - Mode field bits 3 to 0 selects operation, reads current state, resets to boot.
// - Mode two converts once then returns idle; mode three converts until another mode is written.
// - After reset mode reads boot, unwritable, then moves to idle when setup completes.
`timescale 1ns/1ps

// ****************************************************************************
// Serial link end, clocked by the host's serial clock
// ****************************************************************************
module afe_spi_link
   import afe_pkg::*;
(
   input  wire logic        sck_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        sdi_i,
   input  wire logic [23:0] rd_hold_i,
   output logic             sdo_o,
   output logic             sdo_oe_o,
   output logic             wr_req_o,
   output logic             rd_req_o,
   output logic             rs_req_o,
   output logic [3:0]       addr_o,
   output logic [23:0]      wdata_o
);

   typedef struct packed {
      logic [5:0]  bits;
      logic [7:0]  cmd;
      logic [23:0] shift_in;
      logic [23:0] shift_out;
      logic        wr_req;
      logic        rd_req;
      logic        rs_req;
      logic [23:0] wdata;
   } afe_link_st_t;

   localparam afe_link_st_t LINK_IDLE = '0;

   afe_link_st_t s;
   afe_link_st_t next_s;
   logic [1:0]   cmd_len;
   logic [5:0]   wr_last;
   logic         is_reset;

   // Command decode used by the next-state logic.
   assign is_reset = (s.cmd == CMD_RESET);
   assign cmd_len  = afe_reg_len(s.cmd[3:0]);
   assign wr_last  = CMD_LAST + {1'b0, cmd_len, 3'h0};

   // ************************************************************************
   // Frame sequencing
   // ************************************************************************

   // The frame state is built from the request lines and the shifters.
   always_comb
   begin
      next_s           = s;
      next_s.shift_in  = {s.shift_in[22:0], sdi_i};
      next_s.shift_out = {s.shift_out[22:0], 1'b0};
      if (s.bits != BITS_MAX)
      begin
         next_s.bits = s.bits + 6'h01;
      end
      if (s.bits == CMD_LAST)
      begin
         next_s.cmd = {s.shift_in[6:0], sdi_i};
         if ({s.shift_in[6:0], sdi_i} == CMD_RESET)
         begin
            next_s.rs_req = 1'b1;
         end
         else if (s.shift_in[CMD_READ_BIT - 1] == 1'b1)
         begin
            next_s.rd_req = 1'b1;
         end
      end
      if (!is_reset && s.cmd[CMD_READ_BIT] && s.bits == TURN_LAST)
      begin
         next_s.shift_out = rd_hold_i;    // Already justified to the top bit.
      end
      if (!is_reset && !s.cmd[CMD_READ_BIT] && s.cmd[CMD_WRITE_BIT] && cmd_len != LEN_NONE
          && s.bits == wr_last)
      begin
         next_s.wr_req = 1'b1;
         next_s.wdata  = {s.shift_in[22:0], sdi_i} & afe_len_mask(cmd_len);
      end
   end

   // The serial clock stops between frames, so the deselect level clears the
   // frame asynchronously; the request levels fall with it, so the next frame
   // gives the main clock side, which watches for rising edges, a fresh edge.
   always_ff @(negedge sck_i or posedge chip_select_n_i)
   begin
      if (chip_select_n_i)
      begin
         s <= LINK_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs of the link end.
   assign sdo_o    = s.shift_out[23];
   assign sdo_oe_o = ~chip_select_n_i;
   assign wr_req_o = s.wr_req;
   assign rd_req_o = s.rd_req;
   assign rs_req_o = s.rs_req;
   assign addr_o   = s.cmd[3:0];
   assign wdata_o  = s.wdata;

endmodule : afe_spi_link

// ****************************************************************************
// Register bank, clocked by the main clock
// ****************************************************************************
module afe_spi_register_bank
   import afe_pkg::*;
(
   input  wire logic        mclk_i,
   input  wire logic        rst_i,
   input  wire logic        sck_i,
   input  wire logic        chip_select_n_i,
   input  wire logic        sdi_i,
   output logic             sdo_o,
   output logic             sdo_oe_o,
   input  wire afe_conv_t   conv_i,
   input  wire logic        boot_done_i,
   output afe_cfg_t         cfg_o,
   output logic [2:0]       neg_input_select_o,
   output logic [2:0]       pos_input_select_o,
   output logic [3:0]       mode_o,
   output logic [1:0]       update_counter_o,
   output logic             data_pending_n_o,
   output logic             result_overflow_o,
   output logic [15:0]      conversion_result_o
);

   typedef struct packed {
      logic [15:0][23:0] bank;
      logic [2:0]        neg_sel;
      logic [2:0]        pos_sel;
      logic [1:0]        cnt;
      logic              pend_n;
      logic              ovf;
      logic [3:0]        mode;
      logic [15:0]       result;
      logic [23:0]       rd_hold;
      logic [2:0]        wr_sync;
      logic [2:0]        rd_sync;
      logic [2:0]        rs_sync;
   } afe_bank_st_t;

   afe_bank_st_t s;
   afe_bank_st_t next_s;
   logic         wr_req;
   logic         rd_req;
   logic         rs_req;
   logic [3:0]   link_addr;
   logic [23:0]  link_wdata;
   logic         wr_evt;
   logic         rd_evt;
   logic         rs_evt;
   logic         mode_wr;

   // ************************************************************************
   // Helper functions
   // ************************************************************************

   // Access kind of each mapped register; the control word is mixed and is
   // handled field by field elsewhere.
   function automatic afe_access_t reg_access(input logic [3:0] addr);
      case (addr)
         ADDR_CONVERSION_RESULT: reg_access = ACC_RO;
         ADDR_EXCITATION_CONFIG, ADDR_AMP_CONFIG, ADDR_CLOCK_CONFIG, ADDR_OPTION_CONFIG,
         ADDR_GAIN_COEFF_A, ADDR_GAIN_COEFF_B, ADDR_OFFSET_COEFF_A, ADDR_OFFSET_COEFF_B:
                                 reg_access = ACC_RW;
         default:                reg_access = ACC_RO;
      endcase
   endfunction : reg_access

   // Reset value of each bank entry; unused entries stay at zero.
   function automatic logic [23:0] reg_reset(input logic [3:0] addr);
      case (addr)
         ADDR_EXCITATION_CONFIG: reg_reset = EXC_RST;
         ADDR_AMP_CONFIG:        reg_reset = AMP_RST;
         ADDR_CLOCK_CONFIG:      reg_reset = CLK_RST;
         ADDR_OPTION_CONFIG:     reg_reset = OPT_RST;
         ADDR_GAIN_COEFF_A,
         ADDR_GAIN_COEFF_B:      reg_reset = GAIN_RST;
         ADDR_OFFSET_COEFF_A,
         ADDR_OFFSET_COEFF_B:    reg_reset = OFFS_RST;
         default:                reg_reset = 24'h000000;
      endcase
   endfunction : reg_reset

   // New content of a register after a host write, by access kind.
   function automatic logic [23:0] apply_write(input logic [23:0] old, input logic [23:0] wdata,
                                               input afe_access_t acc);
      case (acc)
         ACC_RW, ACC_WO: apply_write = wdata;
         ACC_RC:         apply_write = old & ~wdata;
         default:        apply_write = old;
      endcase
   endfunction : apply_write

   // Value a host read returns, justified so that its first byte leads.
   function automatic logic [23:0] read_value(input afe_bank_st_t st, input logic [3:0] addr);
      logic [23:0] raw;
      logic [1:0]  len;
      raw = 24'h000000;
      len = afe_reg_len(addr);
      raw[NEG_SEL_LSB +: 3] = (addr == ADDR_CONTROL_STATUS) ? st.neg_sel : 3'h0;
      raw[POS_SEL_LSB +: 3] = (addr == ADDR_CONTROL_STATUS) ? st.pos_sel : 3'h0;
      if (addr == ADDR_CONTROL_STATUS)
      begin
         raw[CNT_LSB +: 2]  = st.cnt;
         raw[PEND_BIT]      = st.pend_n;
         raw[OVF_BIT]       = st.ovf;
         raw[MODE_LSB +: 4] = st.mode;
      end
      else if (addr == ADDR_CONVERSION_RESULT)
      begin
         raw = {8'h00, st.result};
      end
      else if (reg_access(addr) != ACC_WO)
      begin
         raw = st.bank[addr];
      end
      raw = raw & afe_len_mask(len);
      case (len)
         LEN_1:   read_value = {raw[7:0], 16'h0000};
         LEN_2:   read_value = {raw[15:0], 8'h00};
         default: read_value = raw;
      endcase
   endfunction : read_value

   // Whole reset image of the bank, crossing flops excluded.
   function automatic afe_bank_st_t reset_image(input afe_bank_st_t st);
      afe_bank_st_t img;
      img = st;
      for (int i = 0; i < 16; i++)
      begin
         img.bank[i] = reg_reset(4'(i));
      end
      img.neg_sel = NEG_SEL_RST;
      img.pos_sel = POS_SEL_RST;
      img.cnt     = CNT_RST;
      img.pend_n  = PEND_RST;
      img.ovf     = OVF_RST;
      img.mode    = MODE_BOOT;
      img.result  = RESULT_RST;
      img.rd_hold = 24'h000000;
      reset_image = img;
   endfunction : reset_image

   // ************************************************************************
   // Link end and crossings
   // ************************************************************************

   // The serial side of the block lives on the host's clock.
   afe_spi_link u_link (
      .sck_i           (sck_i),
      .chip_select_n_i (chip_select_n_i),
      .sdi_i           (sdi_i),
      .rd_hold_i       (s.rd_hold),
      .sdo_o           (sdo_o),
      .sdo_oe_o        (sdo_oe_o),
      .wr_req_o        (wr_req),
      .rd_req_o        (rd_req),
      .rs_req_o        (rs_req),
      .addr_o          (link_addr),
      .wdata_o         (link_wdata)
   );

   // Request levels pass two flops; a third copy gives the rising edge. The
   // address and data words stay still until the frame ends, long after the
   // edge is seen, so they are sampled only on that edge.
   assign wr_evt = s.wr_sync[1] & ~s.wr_sync[2];
   assign rd_evt = s.rd_sync[1] & ~s.rd_sync[2];
   assign rs_evt = s.rs_sync[1] & ~s.rs_sync[2];
   assign mode_wr = wr_evt && link_addr == ADDR_CONTROL_STATUS && s.mode != MODE_BOOT
                    && link_wdata[MODE_LSB +: 4] != MODE_BOOT;

   // ************************************************************************
   // Register state
   // ************************************************************************

   // Host requests first, then the converter's events, which win any clash except a host mode write, applied last.
   always_comb
   begin
      next_s         = s;
      next_s.wr_sync = {s.wr_sync[1:0], wr_req};
      next_s.rd_sync = {s.rd_sync[1:0], rd_req};
      next_s.rs_sync = {s.rs_sync[1:0], rs_req};
      if (rst_i || rs_evt)
      begin
         next_s = reset_image(next_s);
      end
      else
      begin
         if (rd_evt)
         begin
            next_s.rd_hold = read_value(s, link_addr);
            if (link_addr == ADDR_CONVERSION_RESULT)
            begin
               next_s.pend_n = 1'b1;
               next_s.ovf    = 1'b0;
            end
         end
         if (wr_evt && link_addr == ADDR_CONTROL_STATUS)
         begin
            next_s.neg_sel = link_wdata[NEG_SEL_LSB +: 3];
            next_s.pos_sel = link_wdata[POS_SEL_LSB +: 3];
         end
         else if (wr_evt && reg_access(link_addr) != ACC_RO)
         begin
            next_s.bank[link_addr] = apply_write(s.bank[link_addr], link_wdata, reg_access(link_addr))
                                     & afe_len_mask(afe_reg_len(link_addr));
         end
         if (s.mode == MODE_BOOT && boot_done_i)
         begin
            next_s.mode = MODE_IDLE;
         end
         if (conv_i.valid)
         begin
            next_s.result = conv_i.data;
            next_s.cnt    = s.cnt + 2'h1;
            next_s.pend_n = 1'b0;
            next_s.ovf    = conv_i.overflow;
            if (s.mode == MODE_SINGLE)
            begin
               next_s.mode = MODE_IDLE;
            end
         end
         if (mode_wr)
         begin
            next_s.mode = link_wdata[MODE_LSB +: 4];
         end
      end
   end

   // One register stage for the whole bank.
   always_ff @(posedge mclk_i)
   begin
      s <= next_s;
   end

   // ************************************************************************
   // Outputs
   // ************************************************************************

   // Setup registers feed the analog blocks straight from the bank.
   assign cfg_o.excitation    = s.bank[ADDR_EXCITATION_CONFIG][15:0];
   assign cfg_o.amp           = s.bank[ADDR_AMP_CONFIG][7:0];
   assign cfg_o.clock         = s.bank[ADDR_CLOCK_CONFIG][7:0];
   assign cfg_o.option        = s.bank[ADDR_OPTION_CONFIG][7:0];
   assign cfg_o.gain_a        = s.bank[ADDR_GAIN_COEFF_A];
   assign cfg_o.gain_b        = s.bank[ADDR_GAIN_COEFF_B];
   assign cfg_o.offset_a      = s.bank[ADDR_OFFSET_COEFF_A];
   assign cfg_o.offset_b      = s.bank[ADDR_OFFSET_COEFF_B];
   assign neg_input_select_o  = s.neg_sel;
   assign pos_input_select_o  = s.pos_sel;
   assign mode_o              = s.mode;    // Mode three holds until the host writes another mode.
   assign update_counter_o    = s.cnt;
   assign data_pending_n_o    = s.pend_n;
   assign result_overflow_o   = s.ovf;
   assign conversion_result_o = s.result;

endmodule : afe_spi_register_bank

/* File: bench/afe_spi_register_bank_properties.sv */
`timescale 1ns/1ps
// ********************
// Conversion and mode checks
// ********************
module afe_spi_register_bank_properties
   import afe_pkg::*;
(
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire afe_conv_t   conv_i,
   input wire logic        boot_done_i,
   input wire logic [3:0]  mode_o,
   input wire logic [1:0]  update_counter_o,
   input wire logic        data_pending_n_o,
   input wire logic        result_overflow_o,
   input wire logic [15:0] conversion_result_o
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   // A converter result and the boot exit are the steps checked here; host accesses also move these fields.
   sequence s_conv;
      conv_i.valid;
   endsequence
   sequence s_boot;
      mode_o == MODE_BOOT && boot_done_i;
   endsequence
   a_result_load: assert property (
      s_conv |=> conversion_result_o == $past(conv_i.data) && !data_pending_n_o)
      else $error("result not taken");
   a_overflow_copy: assert property (s_conv |=> result_overflow_o == $past(conv_i.overflow))
      else $error("overflow not copied");
   a_count_step: assert property (s_conv |=> update_counter_o == $past(update_counter_o) + 2'h1)
      else $error("counter not stepped");
   // A serial reset command may also clear the counter, so that case is let through.
   a_count_only: assert property (
      !$stable(update_counter_o) |-> $past(conv_i.valid) || update_counter_o == CNT_RST)
      else $error("counter moved alone");
   a_single_idle: assert property (s_conv ##0 mode_o == MODE_SINGLE |=> mode_o == MODE_IDLE)
      else $error("single did not end");
   a_cont_stays: assert property (s_conv ##0 mode_o == MODE_CONT |=> mode_o == MODE_CONT)
      else $error("continuous mode left");
   a_boot_exit: assert property (s_boot |=> mode_o == MODE_IDLE)
      else $error("boot not left");
   a_boot_hold: assert property (mode_o == MODE_BOOT && !boot_done_i |=> mode_o == MODE_BOOT)
      else $error("boot left early");
endmodule : afe_spi_register_bank_properties

bind afe_spi_register_bank afe_spi_register_bank_properties u_props (.mclk_i, .rst_i, .conv_i, .boot_done_i,
   .mode_o, .update_counter_o, .data_pending_n_o, .result_overflow_o, .conversion_result_o);

/* File: bench/afe_spi_host.sv */
`timescale 1ns/1ps
// ********************
// Serial host model
// ********************
module afe_spi_host
(
   output logic      sck_o,
   output logic      chip_select_n_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   // The serial clock stands low between frames.
   initial
   begin
      sck_o = 1'b0;
      chip_select_n_o = 1'b0;
      sdi_o = 1'b0;
      // A clean rising select edge after time zero clears the link logic for sure.
      #1 chip_select_n_o = 1'b1;
   end
   // One frame, MSB first; sdo is gathered from the seventeenth rising edge on.
   task automatic xfer(input logic [39:0] tx, input int nbits, output logic [23:0] rx);
      rx = 24'h000000;
      #3 chip_select_n_o = 1'b0;
      #45;
      for (int k = 1; k <= nbits; k++)
      begin
         sdi_o = tx[nbits - k];
         #20 sck_o = 1'b1;
         if (k > 16)
            rx = {rx[22:0], sdo_i};
         #40 sck_o = 1'b0;
         #20;
      end
      #25 chip_select_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #45;
   endtask : xfer
endmodule : afe_spi_host

/* File: bench/test_afe_spi_register_bank.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
// ********************
// Bench top
// ********************
module test_afe_spi_register_bank
   import afe_pkg::*;
;
   logic        mclk      = 1'b0;
   logic        rst       = 1'b1;
   logic        boot_done = 1'b0;
   afe_conv_t   conv      = '0;
   logic        sck, cs_n, sdi, sdo, sdo_oe, sdo_w, pend_n, ovf, e_pend, e_ovf;
   afe_cfg_t    cfg, e_cfg;
   logic [2:0]  neg_sel, pos_sel, e_neg, e_pos;
   logic [3:0]  mode, e_mode, m;
   logic [1:0]  cnt, e_cnt;
   logic [15:0] result, e_res;
   logic [23:0] exp_reg [16];
   logic [23:0] rd, d;
   int          mismatches = 0;
   int          compares   = 0;
   int          cycles     = 0;
   // Main clock; the released output line toggles so a stale bit never passes for data.
   always #5 mclk = ~mclk;
   assign sdo_w = sdo_oe ? sdo : ~mclk;
   afe_spi_register_bank u_dut (
      .mclk_i(mclk), .rst_i(rst), .sck_i(sck), .chip_select_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo),
      .sdo_oe_o(sdo_oe), .conv_i(conv), .boot_done_i(boot_done), .cfg_o(cfg), .neg_input_select_o(neg_sel),
      .pos_input_select_o(pos_sel), .mode_o(mode), .update_counter_o(cnt), .data_pending_n_o(pend_n),
      .result_overflow_o(ovf), .conversion_result_o(result));
   afe_spi_host u_host (.sck_o(sck), .chip_select_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_w));
   // A hang is cut short well beyond the expected run length.
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         complete_run();
      end
   end
   function automatic int len_of(input logic [3:0] a);
      case (a)
         4'h0, 4'h1, 4'h2:       return 2;
         4'h3, 4'h4, 4'h6:       return 1;
         4'h8, 4'h9, 4'hC, 4'hD: return 3;
         default:                return 0;
      endcase
   endfunction : len_of
   function automatic logic [23:0] ctrl_exp();
      return {8'h00, 1'b0, e_neg, 1'b0, e_pos, e_cnt, e_pend, e_ovf, e_mode};
   endfunction : ctrl_exp
   task automatic reset_image();
      e_neg   = NEG_SEL_RST;
      e_pos   = POS_SEL_RST;
      e_cnt   = CNT_RST;
      e_pend  = PEND_RST;
      e_ovf   = OVF_RST;
      e_mode  = MODE_BOOT;
      e_res   = RESULT_RST;
      exp_reg = '{default: 24'h000000};
   endtask : reset_image
   // Unused addresses still get one data byte so the frame is well formed.
   task automatic wr(input logic [3:0] a, input logic [23:0] v);
      int n;
      n = (len_of(a) == 0) ? 1 : len_of(a);
      u_host.xfer((40'({4'h4, a}) << (8 * n)) | (40'(v) & ((40'h1 << (8 * n)) - 40'h1)), 8 + 8 * n, rd);
   endtask : wr
   task automatic rd_reg(input logic [3:0] a);
      int n;
      n = (len_of(a) == 0) ? 3 : len_of(a);
      u_host.xfer(40'({4'h8, a}) << (8 + 8 * n), 16 + 8 * n, rd);
   endtask : rd_reg
   task automatic chk_ctrl();
      rd_reg(ADDR_CONTROL_STATUS);
      `CHK(rd, ctrl_exp())
      `CHK(neg_sel, e_neg)
      `CHK(pos_sel, e_pos)
      `CHK({cnt, pend_n, ovf}, {e_cnt, e_pend, e_ovf})
      `CHK(mode, e_mode)
   endtask : chk_ctrl
   task automatic chk_regs();
      for (int a = 1; a < 16; a++)
      begin
         rd_reg(4'(a));
         `CHK(rd, exp_reg[a])
      end
   endtask : chk_regs
   task automatic convert(input logic o);
      e_res = 16'($urandom);
      @(posedge mclk);
      conv <= {1'b1, o, e_res};
      @(posedge mclk);
      conv <= '0;
      e_cnt  = e_cnt + 2'h1;
      e_pend = 1'b0;
      e_ovf  = o;
      if (e_mode == MODE_SINGLE)
         e_mode = MODE_IDLE;
      #1;
      `CHK(result, e_res)
      `CHK({cnt, pend_n}, {e_cnt, e_pend})
      `CHK(ovf, e_ovf)
      `CHK(mode, e_mode)
   endtask : convert
   task automatic complete_run();
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   // Main sequence: reset image, boot, control writes, setup registers, conversions, reset command.
   initial
   begin
      void'($urandom(32'h82619d49));
      reset_image();
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      chk_ctrl();
      chk_regs();
      wr(ADDR_CONTROL_STATUS, 24'h004403);
      chk_ctrl();
      @(posedge mclk);
      boot_done <= 1'b1;
      @(posedge mclk);
      boot_done <= 1'b0;
      e_mode = MODE_IDLE;
      repeat (7)
      begin
         e_neg = 3'($urandom);
         e_pos = 3'($urandom);
         m = 4'($urandom_range(0, 9));
         e_mode = (m > 4'h7) ? m + 4'h4 : m;
         wr(ADDR_CONTROL_STATUS, {8'h00, 1'b1, e_neg, 1'b1, e_pos, 4'hF, e_mode});
         chk_ctrl();
      end
      wr(ADDR_CONTROL_STATUS, {8'h00, 1'b0, e_neg, 1'b0, e_pos, 4'h0, MODE_BOOT});
      chk_ctrl();
      for (int a = 1; a < 16; a++)
      begin
         d = 24'($urandom);
         wr(4'(a), d);
         exp_reg[a] = (a == 1) ? 24'h000000 : d & ((24'h1 << (8 * len_of(4'(a)))) - 24'h1);
      end
      chk_regs();
      `CHK(cfg.gain_b, exp_reg[9])
      e_cfg = {exp_reg[2][15:0], exp_reg[3][7:0], exp_reg[4][7:0], exp_reg[6][7:0],
               exp_reg[8], exp_reg[9], exp_reg[12], exp_reg[13]};
      `CHK(cfg, e_cfg)
      wr(ADDR_CONTROL_STATUS, {8'h00, 1'b0, e_neg, 1'b0, e_pos, 4'h0, MODE_SINGLE});
      e_mode = MODE_SINGLE;
      convert(1'b1);
      wr(ADDR_CONTROL_STATUS, {8'h00, 1'b0, e_neg, 1'b0, e_pos, 4'h0, MODE_CONT});
      e_mode = MODE_CONT;
      repeat (5) convert(1'($urandom));
      convert(1'b1);
      rd_reg(ADDR_CONVERSION_RESULT);
      `CHK(rd, {8'h00, e_res})
      `CHK(pend_n, 1'b1)
      `CHK(ovf, 1'b0)
      e_pend = 1'b1;
      e_ovf  = 1'b0;
      chk_ctrl();
      u_host.xfer(40'(CMD_RESET), 8, rd);
      reset_image();
      `CHK(mode, MODE_BOOT)
      `CHK(cfg, '0)
      chk_ctrl();
      chk_regs();
      complete_run();
   end
endmodule : test_afe_spi_register_bank
